// ---- dcfft_pkg.sv ----
// What this block does
// (RULE1) Full flag rises on a write edge once the read pointer has crossed over.
// (RULE2) Empty flag rises on a read edge once the write pointer has crossed over.
// (RULE3) Clocks may run freely while the reset input is held active.
// (RULE4) After reset data reads low; output enable bit high releases the data pins.
// (RULE5) First stored word appears in the read cycle after empty flag rises.
// (RULE6) First-read latency at empty boundary is bounded by the pointer crossing.
// (RULE7) Synchronous mode: almost-empty changes only on a read-side clock edge.
// (RULE8) Synchronous mode: almost-full changes only on a write-side clock edge.
// (RULE9) Almost-empty low means the FIFO holds the empty offset or fewer words.
// (RULE10) Almost-full low once count reaches depth minus the full offset.
// (RULE11) Reset or replay pulses shorter than their minimum width are ignored.
// (RULE12) All flags are valid once the replay recovery time has elapsed. Code: full and half-full flags settle one edge after the recovery window.
// (RULE13) Synchronous almost flags refresh on one clock after replay recovery.
// (RULE14) Write cascade output pulses after writing the last physical location.
// (RULE15) Read cascade output pulses after reading the last physical location.
// (RULE16) Sync select low: almost flags clocked per side; high: taken from true pointers.
// (RULE17) Half-full flag is low while the FIFO holds 8193 or more words.
// (RULE18) Reads blocked while empty flag low; writes blocked while full flag low.
// (RULE19) Pointers cross sides as gray codes through two-stage synchronisers.
package dcfft_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int DCFFT_DEPTH = 16384;
  localparam int DCFFT_WIDTH = 18;
  localparam int DCFFT_OFS_W = 14;
  localparam logic [13:0] DCFFT_EMPTY_OFS_RST = 14'h007F;
  localparam logic [13:0] DCFFT_FULL_OFS_RST = 14'h007F;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int DCFFT_CLK_PERIOD_NS = 50;
  localparam int DCFFT_REPLAY_RECOVERY_NS = 60;
  localparam int DCFFT_REPLAY_PULSE_NS = 30;
  localparam int DCFFT_RESET_PULSE_NS = 10;
  localparam int DCFFT_REPLAY_RECOVERY_CYC =
    (DCFFT_REPLAY_RECOVERY_NS + DCFFT_CLK_PERIOD_NS - 1) / DCFFT_CLK_PERIOD_NS;
  localparam int DCFFT_REPLAY_PULSE_CYC =
    (DCFFT_REPLAY_PULSE_NS + DCFFT_CLK_PERIOD_NS - 1) / DCFFT_CLK_PERIOD_NS;
  localparam int DCFFT_RESET_PULSE_CYC =
    (DCFFT_RESET_PULSE_NS + DCFFT_CLK_PERIOD_NS - 1) / DCFFT_CLK_PERIOD_NS;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam int DCFFT_AXI_AW = 5;
  localparam logic [4:0] DCFFT_REG_CTRL = 5'h00;
  localparam logic [4:0] DCFFT_REG_EMPTY_OFS = 5'h04;
  localparam logic [4:0] DCFFT_REG_FULL_OFS = 5'h08;
  localparam logic [4:0] DCFFT_REG_FLAGS = 5'h0C;
  localparam logic [4:0] DCFFT_REG_LEVEL = 5'h10;
  localparam logic [4:0] DCFFT_REG_IRQ_STAT = 5'h14;
  localparam logic [4:0] DCFFT_REG_IRQ_MASK = 5'h18;

  // Control fields
  localparam int DCFFT_CTRL_SYNC_SEL_BIT = 0;
  localparam int DCFFT_CTRL_OUT_DIS_BIT = 1;

  // Interrupt events
  localparam int DCFFT_IRQ_W = 4;
  localparam int DCFFT_IRQ_WR_REFUSED = 0;
  localparam int DCFFT_IRQ_RD_REFUSED = 1;
  localparam int DCFFT_IRQ_ALMOST_FULL = 2;
  localparam int DCFFT_IRQ_ALMOST_EMPTY = 3;

  localparam logic [1:0] DCFFT_RESP_OKAY = 2'h0;
  localparam logic [1:0] DCFFT_RESP_SLVERR = 2'h2;

  // Status flags, all active low; packing order is the FLAGS register layout
  typedef struct packed {
    logic empty_flag_n;
    logic almost_empty_n;
    logic half_full_n;
    logic almost_full_n;
    logic full_flag_n;
  } dcfft_flags_s;

endpackage : dcfft_pkg

// ---- dcfft_top.sv ----
// Added by the designer: the register offsets and register access over AXI4-Lite.
module dcfft_top #(
  parameter int DEPTH = dcfft_pkg::DCFFT_DEPTH,
  parameter int WIDTH = dcfft_pkg::DCFFT_WIDTH
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic fifo_reset_n, // FIFO reset pin, active low
  input wire logic replay_pulse, // Retransmit request pin, active high
  input wire logic wr_en, // Write request
  input wire logic [WIDTH-1:0] wr_data, // Write data
  input wire logic rd_en, // Read request
  output logic [WIDTH-1:0] rd_data, // Read data register
  output logic rd_data_oe_n, // Data pin drive enable, low drives
  output dcfft_pkg::dcfft_flags_s flags, // Status flags
  output logic write_cascade_out, // Last location written pulse
  output logic read_cascade_out, // Last location read pulse
  output logic irq, // Interrupt level
  input wire logic [dcfft_pkg::DCFFT_AXI_AW-1:0] s_axi_awaddr, // AXI write address
  input wire logic s_axi_awvalid, // AXI write address valid
  output logic s_axi_awready, // AXI write address ready
  input wire logic [31:0] s_axi_wdata, // AXI write data
  input wire logic [3:0] s_axi_wstrb, // AXI byte strobes
  input wire logic s_axi_wvalid, // AXI write data valid
  output logic s_axi_wready, // AXI write data ready
  output logic [1:0] s_axi_bresp, // AXI write response
  output logic s_axi_bvalid, // AXI write response valid
  input wire logic s_axi_bready, // AXI write response ready
  input wire logic [dcfft_pkg::DCFFT_AXI_AW-1:0] s_axi_araddr, // AXI read address
  input wire logic s_axi_arvalid, // AXI read address valid
  output logic s_axi_arready, // AXI read address ready
  output logic [31:0] s_axi_rdata, // AXI read data
  output logic [1:0] s_axi_rresp, // AXI read response
  output logic s_axi_rvalid, // AXI read data valid
  input wire logic s_axi_rready // AXI read ready
);
  import dcfft_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
  localparam logic [PW-1:0] HALF_P = PW'(DEPTH / 2 + 1);
  localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    for (int i = PW - 1; i >= 0; i--) begin
      b[i] = g[i] ^ ((i == PW - 1) ? 1'b0 : b[i+1]);
    end
    return b;
  endfunction : gray2bin

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : apply_strb

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];
  logic rst_s1, rst_s2, rp_s1, rp_s2;
  logic [7:0] rst_lo_cnt, rp_hi_cnt, rec_cnt;
  logic fifo_rst, replay_go, busy;
  logic [PW-1:0] wptr, rptr, next_wptr, next_rptr, replay_ptr;
  logic [PW-1:0] wgray, rgray, wg_s1, wg_s2, rg_s1, rg_s2;
  logic [PW-1:0] wcount, rcount, true_count;
  logic wr_go, rd_go;
  logic sync_sel, out_dis;
  logic [DCFFT_OFS_W-1:0] empty_ofs, full_ofs;
  logic [DCFFT_IRQ_W-1:0] irq_stat, irq_mask, irq_ev, next_irq_stat;
  logic next_af_n, next_ae_n;
  logic aw_held, w_held, do_write, next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [DCFFT_AXI_AW-1:0] wr_addr;
  logic [31:0] wr_word;
  logic [3:0] wr_strb;

  // ----------------------------------------
  // Pin synchronisers and pulse qualification
  // ----------------------------------------
  // Both pins come from outside, so two flops before any logic looks at them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_s1 <= 1'b1;
      rst_s2 <= 1'b1;
      rp_s1 <= 1'b0;
      rp_s2 <= 1'b0;
    end else begin
      rst_s1 <= fifo_reset_n;
      rst_s2 <= rst_s1;
      rp_s1 <= replay_pulse;
      rp_s2 <= rp_s1;
    end
  end

  // Width counters; a glitch narrower than a clock reaches the second flop only if an edge samples it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_lo_cnt <= 8'h00;
      rp_hi_cnt <= 8'h00;
    end else begin
      rst_lo_cnt <= rst_s2 ? 8'h00 : ((rst_lo_cnt == 8'hFF) ? rst_lo_cnt : rst_lo_cnt + 8'h01); // RULE11
      rp_hi_cnt <= !rp_s2 ? 8'h00 : ((rp_hi_cnt == 8'hFF) ? rp_hi_cnt : rp_hi_cnt + 8'h01); // RULE11
    end
  end

  // Reset only counts once held its minimum width; clocks keep running meanwhile
  assign fifo_rst = !aresetn || (!rst_s2 && (rst_lo_cnt >= 8'(DCFFT_RESET_PULSE_CYC - 1))); // RULE11 RULE3
  assign replay_go = rp_s2 && (rp_hi_cnt == 8'(DCFFT_REPLAY_PULSE_CYC - 1)); // RULE11
  assign busy = (rec_cnt != 8'h00);

  // Recovery window after a replay; all traffic held off for two cycles, and the full and half-full flags settle one edge later
  always_ff @(posedge aclk) begin
    if (fifo_rst) begin
      rec_cnt <= 8'h00;
    end else if (replay_go) begin
      rec_cnt <= 8'(DCFFT_REPLAY_RECOVERY_CYC); // RULE12
    end else if (busy) begin
      rec_cnt <= rec_cnt - 8'h01;
    end
  end

  // ----------------------------------------
  // Pointers and storage
  // ----------------------------------------
  assign wr_go = wr_en && flags.full_flag_n && !busy && !fifo_rst; // RULE18
  assign rd_go = rd_en && flags.empty_flag_n && !busy && !fifo_rst; // RULE18
  assign next_wptr = wr_go ? wptr + PW'(1) : wptr;
  // Replay jumps to location zero; a write pointer at location zero gives the full count
  assign replay_ptr = {wptr[PW-1] ^ (wptr[AW-1:0] == '0), {AW{1'b0}}};
  assign next_rptr = replay_go ? replay_ptr : (rd_go ? rptr + PW'(1) : rptr);

  always_ff @(posedge aclk) begin
    if (fifo_rst) begin
      wptr <= '0;
      rptr <= '0;
      wgray <= '0;
      rgray <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      wgray <= bin2gray(next_wptr); // RULE19
      rgray <= bin2gray(next_rptr); // RULE19
    end
  end

  // Storage array has no reset, so it maps onto block memory
  always_ff @(posedge aclk) begin
    if (wr_go) begin
      mem[wptr[AW-1:0]] <= wr_data;
    end
  end

  // Output register; last read word is kept while empty
  always_ff @(posedge aclk) begin
    if (fifo_rst) begin
      rd_data <= '0; // RULE4
    end else if (rd_go) begin
      rd_data <= mem[rptr[AW-1:0]]; // RULE5
    end
  end

  // ----------------------------------------
  // Pointer crossing
  // ----------------------------------------
  // A replay jump moves many gray bits at once; safe here only because both
  // sides share aclk, and the recovery window covers the settle time
  always_ff @(posedge aclk) begin
    if (fifo_rst) begin
      wg_s1 <= '0;
      wg_s2 <= '0;
      rg_s1 <= '0;
      rg_s2 <= '0;
    end else begin
      wg_s1 <= wgray; // RULE19
      wg_s2 <= wg_s1;
      rg_s1 <= rgray; // RULE19
      rg_s2 <= rg_s1;
    end
  end

  assign wcount = next_wptr - gray2bin(rg_s2);
  assign rcount = gray2bin(wg_s2) - next_rptr;
  assign true_count = next_wptr - next_rptr;

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  // Async mode reads the true pointers for a quicker almost flag
  assign next_af_n = sync_sel ? (true_count < DEPTH_P - PW'(full_ofs)) // RULE16
                              : (wcount < DEPTH_P - PW'(full_ofs)); // RULE8 RULE10
  assign next_ae_n = sync_sel ? (true_count > PW'(empty_ofs)) // RULE16
                              : (rcount > PW'(empty_ofs)); // RULE7 RULE9

  // Write-side flags see the read pointer late, so full clears a few edges on
  always_ff @(posedge aclk) begin
    if (fifo_rst) begin
      flags.full_flag_n <= 1'b1;
      flags.almost_full_n <= 1'b1;
      flags.half_full_n <= 1'b1;
    end else begin
      flags.full_flag_n <= (wcount != DEPTH_P); // RULE1
      flags.almost_full_n <= next_af_n; // RULE13
      flags.half_full_n <= (wcount < HALF_P); // RULE17
    end
  end

  // Read-side flags see the write pointer late
  always_ff @(posedge aclk) begin
    if (fifo_rst) begin
      flags.empty_flag_n <= 1'b0;
      flags.almost_empty_n <= 1'b0;
    end else begin
      flags.empty_flag_n <= (rcount != '0); // RULE2 RULE6
      flags.almost_empty_n <= next_ae_n; // RULE13
    end
  end

  // Cascade pulses mark wrap of each physical pointer
  always_ff @(posedge aclk) begin
    if (fifo_rst) begin
      write_cascade_out <= 1'b0;
      read_cascade_out <= 1'b0;
    end else begin
      write_cascade_out <= wr_go && (wptr[AW-1:0] == LAST_ADDR); // RULE14
      read_cascade_out <= rd_go && (rptr[AW-1:0] == LAST_ADDR); // RULE15
    end
  end

  // Drive enable follows the control bit; data stays low until first read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data_oe_n <= 1'b0;
    end else begin
      rd_data_oe_n <= out_dis; // RULE4
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  always_comb begin
    irq_ev = '0;
    irq_ev[DCFFT_IRQ_WR_REFUSED] = wr_en && !flags.full_flag_n && !fifo_rst;
    irq_ev[DCFFT_IRQ_RD_REFUSED] = rd_en && !flags.empty_flag_n && !fifo_rst;
    irq_ev[DCFFT_IRQ_ALMOST_FULL] = flags.almost_full_n && !next_af_n && !fifo_rst;
    irq_ev[DCFFT_IRQ_ALMOST_EMPTY] = flags.almost_empty_n && !next_ae_n && !fifo_rst;
  end

  // Set beats a same-cycle write-one-to-clear
  always_comb begin
    next_irq_stat = irq_stat;
    if (do_write && (wr_addr == DCFFT_REG_IRQ_STAT)) begin
      next_irq_stat = irq_stat & ~DCFFT_IRQ_W'(apply_strb(32'h0, wr_word, wr_strb));
    end
    next_irq_stat = next_irq_stat | irq_ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq <= |(next_irq_stat & irq_mask);
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign next_aw_held = do_write ? 1'b0 : (aw_held || (s_axi_awvalid && s_axi_awready));
  assign next_w_held = do_write ? 1'b0 : (w_held || (s_axi_wvalid && s_axi_wready));
  assign next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
  assign next_rvalid = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);

  // Address and data are taken in either order and held until both arrive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_word <= 32'h0;
      wr_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= DCFFT_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_word <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready <= !next_w_held && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (do_write) begin
        s_axi_bresp <= (wr_addr[1:0] == 2'h0 && wr_addr <= DCFFT_REG_IRQ_MASK) ? DCFFT_RESP_OKAY : DCFFT_RESP_SLVERR;
      end
    end
  end

  // Software-writable settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_sel <= 1'b0;
      out_dis <= 1'b0;
      empty_ofs <= DCFFT_EMPTY_OFS_RST;
      full_ofs <= DCFFT_FULL_OFS_RST;
      irq_mask <= '0;
    end else if (do_write) begin
      case (wr_addr)
        DCFFT_REG_CTRL: begin
          sync_sel <= 1'(apply_strb({30'h0, out_dis, sync_sel}, wr_word, wr_strb) >> DCFFT_CTRL_SYNC_SEL_BIT);
          out_dis <= 1'(apply_strb({30'h0, out_dis, sync_sel}, wr_word, wr_strb) >> DCFFT_CTRL_OUT_DIS_BIT);
        end
        DCFFT_REG_EMPTY_OFS: begin
          empty_ofs <= DCFFT_OFS_W'(apply_strb({18'h0, empty_ofs}, wr_word, wr_strb));
        end
        DCFFT_REG_FULL_OFS: begin
          full_ofs <= DCFFT_OFS_W'(apply_strb({18'h0, full_ofs}, wr_word, wr_strb));
        end
        DCFFT_REG_IRQ_MASK: begin
          irq_mask <= DCFFT_IRQ_W'(apply_strb({28'h0, irq_mask}, wr_word, wr_strb));
        end
        default: begin
        end
      endcase
    end
  end

  // Read channel answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= DCFFT_RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rresp <= DCFFT_RESP_OKAY;
        case (s_axi_araddr)
          DCFFT_REG_CTRL: s_axi_rdata <= {30'h0, out_dis, sync_sel};
          DCFFT_REG_EMPTY_OFS: s_axi_rdata <= {18'h0, empty_ofs};
          DCFFT_REG_FULL_OFS: s_axi_rdata <= {18'h0, full_ofs};
          DCFFT_REG_FLAGS: s_axi_rdata <= {26'h0, busy, flags};
          DCFFT_REG_LEVEL: s_axi_rdata <= 32'(wptr - rptr);
          DCFFT_REG_IRQ_STAT: s_axi_rdata <= {28'h0, irq_stat};
          DCFFT_REG_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= DCFFT_RESP_SLVERR;
          end
        endcase
      end
    end
  end

endmodule : dcfft_top

// ---- dcfft_top_chk.sv ----
// ----------------------------------------
// Port-level checks
// ----------------------------------------
module dcfft_top_chk import dcfft_pkg::*; #(
  parameter int DEPTH = DCFFT_DEPTH,
  parameter int WIDTH = DCFFT_WIDTH
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic fifo_reset_n, // FIFO reset pin
  input wire logic replay_pulse, // Retransmit pin
  input wire logic wr_en, // Write request
  input wire logic rd_en, // Read request
  input wire logic [WIDTH-1:0] rd_data, // Read data
  input wire logic rd_data_oe_n, // Pin drive enable
  input wire dcfft_pkg::dcfft_flags_s flags, // Status flags
  input wire logic write_cascade_out, // Last write pulse
  input wire logic read_cascade_out, // Last read pulse
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid // Read data valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // One clock: skew-dependent flags always take the slow path
  a_reset_vals: assert property ($rose(aresetn) |-> rd_data == '0 && !rd_data_oe_n && flags == 5'h07)
    else $error("outputs not at reset values");
  a_fifo_reset: assert property (!fifo_reset_n [*4] |=> flags == 5'h07 && rd_data == '0)
    else $error("FIFO reset pin not honoured");
  a_empty_rise: assert property ($rose(flags.empty_flag_n) |-> $past(wr_en, 4))
    else $error("empty flag rose off the write timing");
  a_full_rise: assert property ($rose(flags.full_flag_n) && fifo_reset_n |-> $past(rd_en, 4))
    else $error("full flag rose off the read timing");
  a_read_blocked: assert property (!flags.empty_flag_n && fifo_reset_n && $past(fifo_reset_n) |=> $stable(rd_data))
    else $error("read data moved while empty");
  a_wr_casc: assert property (write_cascade_out |-> $past(wr_en) && $past(flags.full_flag_n) && !$past(write_cascade_out))
    else $error("write cascade pulse without a write");
  a_rd_casc: assert property (read_cascade_out |-> $past(rd_en) && $past(flags.empty_flag_n) && !$past(read_cascade_out))
    else $error("read cascade pulse without a read");
  a_full_onset: assert property ($fell(flags.full_flag_n) |-> !flags.half_full_n && !flags.almost_full_n)
    else $error("full without half and almost full");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after take");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");

  c_full: cover property ($fell(flags.full_flag_n));
  c_wr_casc: cover property (write_cascade_out);
  c_replay: cover property (replay_pulse);
  c_empty_rise: cover property ($rose(flags.empty_flag_n));
endmodule : dcfft_top_chk

bind dcfft_top dcfft_top_chk #(.DEPTH(DEPTH), .WIDTH(WIDTH)) u_chk (
  .aclk, .aresetn, .fifo_reset_n, .replay_pulse, .wr_en, .rd_en, .rd_data, .rd_data_oe_n, .flags,
  .write_cascade_out, .read_cascade_out, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid
);

// ---- dcfft_peer.sv ----
// Writer and reader on the FIFO's far side
module dcfft_peer (
  input wire logic aclk, // Clock
  input wire logic wr_go, // Keep writing while high
  input wire logic rd_go, // Keep reading while high
  input wire logic rd_slow, // Stall reads at random
  output logic wr_en = 1'h0, // Write request
  output logic [dcfft_pkg::DCFFT_WIDTH-1:0] wr_data = '0, // Write data
  output logic rd_en = 1'h0 // Read request
);
  import dcfft_pkg::*;

  // Data changes every cycle, so a stale word is never taken as right
  always @(posedge aclk) begin
    wr_en <= wr_go;
    wr_data <= DCFFT_WIDTH'($urandom);
    rd_en <= rd_go && (!rd_slow || $urandom_range(1));
  end
endmodule : dcfft_peer

// ---- testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dcfft_pkg::*;

  localparam int DEPTH = 16;
  logic aclk = '0, aresetn = '0, fifo_reset_n = '1, replay_pulse = '0;
  logic wr_go = '0, rd_go = '0, rd_slow = '0, rd_pend = '0;
  logic wr_en, rd_en, rd_data_oe_n, write_cascade_out, read_cascade_out, irq;
  logic [DCFFT_WIDTH-1:0] wr_data, rd_data;
  dcfft_flags_s flags;
  logic [4:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int bad_count = 0, samples_checked = 0, rd_cnt = 0, wc_cnt = 0, rc_cnt = 0;
  logic [DCFFT_WIDTH-1:0] exp_q[$], wr_hist[$];
  logic [1:0] bexp_q[$];
  logic [33:0] rexp_q[$];
  int chunk[8] = '{3, 1, 4, 1, 2, 1, 4, 1};
  logic [4:0] fexp[8] = '{5'h17, 5'h1F, 5'h1F, 5'h1B, 5'h1B, 5'h19, 5'h18, 5'h18};
  logic [4:0] ra[6] = '{DCFFT_REG_CTRL, DCFFT_REG_EMPTY_OFS, DCFFT_REG_FULL_OFS, DCFFT_REG_LEVEL, DCFFT_REG_IRQ_MASK, 5'h1C};
  logic [31:0] rv[6] = '{32'h0, 32'h7F, 32'h7F, 32'h0, 32'h0, 32'h0};

  always #25 aclk = ~aclk;

  dcfft_top #(.DEPTH(DEPTH)) dut (.aclk, .aresetn, .fifo_reset_n, .replay_pulse, .wr_en, .wr_data, .rd_en, .rd_data,
    .rd_data_oe_n, .flags, .write_cascade_out, .read_cascade_out, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  dcfft_peer peer (.aclk, .wr_go, .rd_go, .rd_slow, .wr_en, .wr_data, .rd_en);

  task automatic check(input string what, input logic [33:0] e, input logic [33:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // Bus cycles start one edge on
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    bexp_q.push_back(er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
    end while (!s_axi_bvalid);
    s_axi_bready <= '0;
  endtask : axi_wr

  task automatic axi_rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
    rexp_q.push_back({er, ed});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= '0;
    end while (!s_axi_rvalid);
    s_axi_rready <= '0;
  endtask : axi_rd

  // Traffic through the peer, then settle
  task automatic feed(input int n);
    wr_go <= '1;
    cyc(n);
    wr_go <= '0;
    cyc(6);
  endtask : feed

  task automatic drain(input int n, input logic slow);
    int t;
    t = rd_cnt + n;
    rd_slow <= slow;
    rd_go <= '1;
    if (slow) begin
      for (int i = 0; i < 500 && rd_cnt < t; i++) @(posedge aclk);
      if (rd_cnt < t) bad_count++;
    end else begin
      cyc(n);
    end
    rd_go <= '0;
    cyc(6);
  endtask : drain

  // Note every write that the FIFO ought to accept
  always @(posedge aclk) begin
    if (aresetn && fifo_reset_n && wr_en && flags.full_flag_n) begin
      exp_q.push_back(wr_data);
      wr_hist.push_back(wr_data);
    end
  end

  // Compare each result with the oldest note
  always @(posedge aclk) begin
    if (rd_pend) begin
      check("rd_data", exp_q.pop_front(), rd_data);
      rd_cnt++;
    end
    rd_pend = aresetn && fifo_reset_n && rd_en && flags.empty_flag_n;
    if (write_cascade_out) wc_cnt++;
    if (read_cascade_out) rc_cnt++;
    if (s_axi_bvalid && s_axi_bready) check("bresp", bexp_q.pop_front(), s_axi_bresp);
    if (s_axi_rvalid && s_axi_rready) check("rdata", rexp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
  end

  // Main sequence
  initial begin
    void'($urandom(32'hECB0));
    cyc(20);
    aresetn <= '1;
    cyc(3);
    check("pins", '0, {irq, rd_data_oe_n, rd_data});
    foreach (ra[i]) axi_rd(ra[i], rv[i], i == 5 ? DCFFT_RESP_SLVERR : DCFFT_RESP_OKAY);
    axi_wr(5'h1C, 32'h1, DCFFT_RESP_SLVERR);
    axi_wr(DCFFT_REG_FLAGS, 32'h1F, DCFFT_RESP_OKAY);
    axi_wr(DCFFT_REG_EMPTY_OFS, 32'h3, DCFFT_RESP_OKAY);
    axi_wr(DCFFT_REG_FULL_OFS, 32'h4, DCFFT_RESP_OKAY);
    axi_wr(DCFFT_REG_IRQ_MASK, 32'hF, DCFFT_RESP_OKAY);
    axi_wr(DCFFT_REG_IRQ_STAT, 32'hF, DCFFT_RESP_OKAY);
    axi_rd(DCFFT_REG_FLAGS, 32'h7, DCFFT_RESP_OKAY);
    drain(1, '0);
    axi_rd(DCFFT_REG_IRQ_STAT, 32'h2, DCFFT_RESP_OKAY);
    axi_wr(DCFFT_REG_IRQ_STAT, 32'h2, DCFFT_RESP_OKAY);
    foreach (chunk[i]) begin
      feed(chunk[i]);
      check("flags", fexp[i], flags);
    end
    check("wr_cascade", 1, wc_cnt);
    axi_rd(DCFFT_REG_LEVEL, 32'h10, DCFFT_RESP_OKAY);
    axi_rd(DCFFT_REG_IRQ_STAT, 32'h5, DCFFT_RESP_OKAY);
    check("irq", 1, irq);
    axi_wr(DCFFT_REG_IRQ_MASK, 32'h0, DCFFT_RESP_OKAY);
    cyc(2);
    check("irq", 0, irq);
    axi_wr(DCFFT_REG_IRQ_STAT, 32'hF, DCFFT_RESP_OKAY);
    axi_wr(DCFFT_REG_IRQ_MASK, 32'hF, DCFFT_RESP_OKAY);
    drain(16, '1);
    check("flags", 5'h07, flags);
    check("rd_cascade", 1, rc_cnt);
    // Replay: rewind after two of four reads
    wr_hist.delete();
    feed(4);
    axi_wr(DCFFT_REG_CTRL, 32'h1, DCFFT_RESP_OKAY);
    drain(2, '0);
    exp_q = wr_hist;
    replay_pulse <= '1;
    cyc(1);
    replay_pulse <= '0;
    cyc(8);
    check("flags", 5'h1F, flags);
    drain(4, '0);
    check("flags", 5'h07, flags);
    axi_wr(DCFFT_REG_CTRL, 32'h2, DCFFT_RESP_OKAY);
    cyc(2);
    check("oe_n", 1, rd_data_oe_n);
    axi_wr(DCFFT_REG_CTRL, 32'h0, DCFFT_RESP_OKAY);
    cyc(2);
    check("oe_n", 0, rd_data_oe_n);
    // Glitch ignored, held pin empties
    feed(3);
    #10 fifo_reset_n = '0;
    #10 fifo_reset_n = '1;
    cyc(4);
    check("flags", 5'h17, flags);
    fifo_reset_n <= '0;
    cyc(5);
    fifo_reset_n <= '1;
    cyc(4);
    exp_q.delete();
    check("flags", 5'h07, flags);
    check("rd_data", 0, rd_data);
    axi_rd(DCFFT_REG_EMPTY_OFS, 32'h3, DCFFT_RESP_OKAY);
    print_verdict();
  end

  // Watchdog, well past the test length
  initial begin
    #500000;
    bad_count++;
    print_verdict();
  end
endmodule : testbench
